// ### rtl/cvic_capture.sv
// Camera video input capture: embedded-sync and gated clock modes
`timescale 1ns/1ps
module cvic_capture
   import cvic_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Configuration, static while capturing
   input  wire cvic_cfg_t         cfg,
   // Sensor pins
   input  wire logic              sensor_pixel_clock,
   input  wire logic              frame_sync_in,
   input  wire logic              line_sync_in,
   input  wire logic [DATA_W-1:0] sensor_pixel_bus,
   // Pixel stream to downstream
   output cvic_pix_t              pix_out,
   output logic                   frame_sync_out,
   output logic                   line_sync_out,
   output logic                   fmt_error
);

   typedef enum logic [1:0] {CV_IDLE, CV_PRE1, CV_PRE2, CV_STATUS} cvic_tc_t;

   logic [DATA_W+2:0] pins_s;
   logic [DATA_W-1:0] bus_s;
   logic              pclk_s;
   logic              fsync_s;
   logic              lsync_s;
   logic              pclk_d_r;
   logic              fsync_d_r;
   logic              lsync_d_r;
   logic [2:0]        ready_r;
   logic              pclk_rise;
   logic              gated;
   logic              dual;
   logic              fmt_ok;
   logic [9:0]        word;
   logic [PIX_W-1:0]  raw;
   logic [PIX_W-1:0]  ext;
   cvic_tc_t          tc_r;
   cvic_tc_t          tc_nxt;
   logic              active_r;
   logic              half_r;
   logic [COMP_W-1:0] hold_r;
   logic              fstart_pend_r;
   logic              lstart_pend_r;
   logic              field_r;

   // All pins share one synchroniser stage pair
   cvic_sync2 #(.W(DATA_W + 3)) u_sync (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     ({sensor_pixel_clock, frame_sync_in, line_sync_in,
                 sensor_pixel_bus}),
      .dout    (pins_s)
   );

   assign pclk_s  = pins_s[DATA_W+2];
   assign fsync_s = pins_s[DATA_W+1] ^ cfg.inv_frame;
   assign lsync_s = pins_s[DATA_W]   ^ cfg.inv_line;
   assign bus_s   = pins_s[DATA_W-1:0];

   // Edges are blocked until the synchroniser and the delayed copies hold
   // real pin levels; otherwise reset values fake an edge after reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ready_r <= '0;
      end else begin
         ready_r <= {ready_r[1:0], 1'b1};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pclk_d_r  <= 1'b0;
         fsync_d_r <= 1'b0;
         lsync_d_r <= 1'b0;
      end else begin
         pclk_d_r  <= pclk_s;
         fsync_d_r <= fsync_s;
         lsync_d_r <= lsync_s;
      end
   end

   assign pclk_rise = pclk_s & ~pclk_d_r & ready_r[2];
   assign gated     = (cfg.mode == MODE_GATED);
   assign dual      = (cfg.mode == MODE_BT_DUAL);

   // Accepted format and protocol pairs
   always_comb begin
      case (cfg.fmt)
         FMT_YUV8:      fmt_ok = (cfg.mode == MODE_BT_SINGLE);
         FMT_YUV20:     fmt_ok = dual;
         FMT_YUV16:     fmt_ok = dual | gated;
         FMT_RGB16,
         FMT_GENERIC:   fmt_ok = 1'b1;
         FMT_RGB16_OTF: fmt_ok = gated;
         default:       fmt_ok = 1'b0;
      endcase
   end

   // Timing codes are detected on the luma lane (upper component)
   assign word = bus_s[DATA_W-1:DATA_W-10];

   always_comb begin
      tc_nxt = tc_r;
      case (tc_r)
         CV_IDLE:   if (word == PRE_ONES) tc_nxt = CV_PRE1;
         CV_PRE1:   tc_nxt = (word == PRE_ZEROS) ? CV_PRE2 : CV_IDLE;
         CV_PRE2:   tc_nxt = (word == PRE_ZEROS) ? CV_STATUS : CV_IDLE;
         CV_STATUS: tc_nxt = (word == PRE_ONES) ? CV_PRE1 : CV_IDLE;
         default:   tc_nxt = CV_IDLE;
      endcase
   end

   // Sync pins are never looked at in embedded mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tc_r <= CV_IDLE;
      end else if (gated) begin
         tc_r <= CV_IDLE;
      end else if (pclk_rise) begin
         tc_r <= tc_nxt;
      end
   end

   // Line and frame state taken from sync pins in gated mode, recovered from status words in embedded modes
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_r      <= 1'b0;
         field_r       <= 1'b0;
         fstart_pend_r <= 1'b0;
         lstart_pend_r <= 1'b0;
      end else if (gated) begin
         active_r <= lsync_s;
         if (fsync_s & ~fsync_d_r & ready_r[2])
            fstart_pend_r <= 1'b1;
         else if (pclk_rise & lsync_s)
            fstart_pend_r <= 1'b0;
         if (lsync_s & ~lsync_d_r & ready_r[2])
            lstart_pend_r <= 1'b1;
         else if (pclk_rise & lsync_s)
            lstart_pend_r <= 1'b0;
      end else if (pclk_rise) begin
         if (tc_r == CV_PRE2 && word == PRE_ZEROS) begin
            // Next word is status; no pixel is in flight
         end
         if (tc_r == CV_STATUS) begin
            // Status word fields: field, vertical blanking, end flag
            if (word[ST_EAV]) begin
               active_r <= 1'b0;
            end else if (!word[ST_VBLANK]) begin
               active_r      <= 1'b1;
               lstart_pend_r <= 1'b1;
               if (field_r != word[ST_FIELD] || !frame_sync_out)
                  fstart_pend_r <= 1'b1;
               field_r <= word[ST_FIELD];
            end
         end else if (active_r && tc_r == CV_IDLE && tc_nxt == CV_IDLE) begin
            fstart_pend_r <= 1'b0;
            lstart_pend_r <= 1'b0;
         end
      end
   end

   // Single-component mode pairs two successive words into one output
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         half_r <= 1'b0;
         hold_r <= '0;
      end else if (gated || !active_r) begin
         half_r <= 1'b0;
      end else if (pclk_rise && tc_r == CV_IDLE && tc_nxt == CV_IDLE
                   && cfg.mode == MODE_BT_SINGLE) begin
         half_r <= ~half_r;
         hold_r <= word;
      end
   end

   assign raw = (cfg.mode == MODE_BT_SINGLE) ?
                {hold_r, word} : bus_s;

   cvic_extend u_ext (
      .fmt (cfg.fmt),
      .raw (raw),
      .ext (ext)
   );

   // Output pixel stream; codes and blanking never reach it
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pix_out <= '0;
      end else begin
         pix_out.valid       <= 1'b0;
         pix_out.frame_start <= 1'b0;
         pix_out.line_start  <= 1'b0;
         pix_out.line_end    <= 1'b0;
         if (!fmt_ok) begin
            pix_out.valid <= 1'b0;
         end else if (gated) begin
            if (pclk_rise & lsync_s) begin
               pix_out.valid       <= 1'b1;
               pix_out.data        <= ext;
               pix_out.frame_start <= fstart_pend_r;
               pix_out.line_start  <= lstart_pend_r;
            end
            pix_out.line_end <= ~lsync_s & lsync_d_r
                                & ready_r[2];
         end else if (pclk_rise) begin
            if (active_r && tc_r == CV_IDLE && tc_nxt == CV_IDLE
                && (dual || half_r)) begin
               pix_out.valid       <= 1'b1;
               pix_out.data        <= ext;
               pix_out.frame_start <= fstart_pend_r;
               pix_out.line_start  <= lstart_pend_r;
               pix_out.field       <= field_r;
            end
            if (tc_r == CV_STATUS && word[ST_EAV] && active_r)
               pix_out.line_end <= 1'b1;
         end
      end
   end

   // Regenerated internal syncs
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_sync_out <= 1'b0;
         line_sync_out  <= 1'b0;
         fmt_error      <= 1'b0;
      end else begin
         fmt_error <= ~fmt_ok;
         if (gated) begin
            frame_sync_out <= fsync_s;
            line_sync_out  <= lsync_s;
         end else begin
            line_sync_out <= active_r;
            if (pclk_rise && tc_r == CV_STATUS)
               frame_sync_out <= ~word[ST_VBLANK];
         end
      end
   end

endmodule : cvic_capture

// ### rtl/cvic_extend.sv
// Colour extension of narrow components to full component width
`timescale 1ns/1ps
module cvic_extend
   import cvic_pkg::*;
(
   // Format select and raw pair
   input  wire logic [2:0]       fmt,
   input  wire logic [PIX_W-1:0] raw,
   // Extended pair
   output logic      [PIX_W-1:0] ext
);
   // Narrow formats keep data in the top bits of each component
   always_comb begin
      ext = raw;
      case (fmt)
         FMT_YUV8, FMT_YUV16: begin
            // Eight-bit components: replicate top two bits into the gap
            ext[PIX_W-1:COMP_W] = {raw[PIX_W-1:PIX_W-8],
                                   raw[PIX_W-1:PIX_W-2]};
            ext[COMP_W-1:0]     = {raw[COMP_W-1:COMP_W-8],
                                   raw[COMP_W-1:COMP_W-2]};
         end
         FMT_RGB16, FMT_RGB16_OTF: begin
            // Nine-bit components: replicate the single top bit
            ext[PIX_W-1:COMP_W] = {raw[PIX_W-1:PIX_W-9],
                                   raw[PIX_W-1]};
            ext[COMP_W-1:0]     = {raw[COMP_W-1:COMP_W-9],
                                   raw[COMP_W-1]};
         end
         default: ext = raw;
      endcase
   end
endmodule : cvic_extend

// ### rtl/cvic_pkg.sv
// Package: constants and types for the camera video input capture block
package cvic_pkg;

   localparam int DATA_W = 20;
   localparam int COMP_W = 10;
   localparam int PIX_W  = 2 * COMP_W;

   // Embedded timing code preamble words (10-bit form) and status flag bits
   localparam logic [9:0] PRE_ONES  = 10'h3FF;
   localparam logic [9:0] PRE_ZEROS = 10'h000;
   localparam int         ST_FIELD  = 8;
   localparam int         ST_VBLANK = 7;
   localparam int         ST_EAV    = 6;

   // Colour formats
   localparam logic [2:0] FMT_GENERIC  = 3'h0;
   localparam logic [2:0] FMT_YUV8     = 3'h1;
   localparam logic [2:0] FMT_RGB16    = 3'h2;
   localparam logic [2:0] FMT_YUV16    = 3'h3;
   localparam logic [2:0] FMT_YUV20    = 3'h4;
   localparam logic [2:0] FMT_RGB16_OTF = 3'h5;

   // Timing modes
   localparam logic [1:0] MODE_BT_SINGLE = 2'h0;
   localparam logic [1:0] MODE_BT_DUAL   = 2'h1;
   localparam logic [1:0] MODE_GATED     = 2'h2;

   typedef struct packed {
      logic              valid;
      logic [PIX_W-1:0]  data;
      logic              frame_start;
      logic              line_start;
      logic              line_end;
      logic              field;
   } cvic_pix_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [2:0] fmt;
      logic       inv_frame;
      logic       inv_line;
   } cvic_cfg_t;

endpackage : cvic_pkg

// ### rtl/cvic_sync2.sv
// Two-flip-flop synchroniser for a bundle of level inputs
`timescale 1ns/1ps
module cvic_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Levels
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule : cvic_sync2

// ### tb/cvic_capture_monitor.sv
// Checker: concurrent properties on the capture block ports
`timescale 1ns/1ps
module cvic_capture_monitor
   import cvic_pkg::*;
(
   // Clock, reset and configuration
   input wire logic              clk,
   input wire logic              sys_rst,
   input wire cvic_cfg_t         cfg,
   // Sensor pins
   input wire logic              sensor_pixel_clock,
   input wire logic              frame_sync_in,
   input wire logic              line_sync_in,
   input wire logic [DATA_W-1:0] sensor_pixel_bus,
   // Downstream side
   input wire cvic_pix_t         pix_out,
   input wire logic              frame_sync_out,
   input wire logic              line_sync_out,
   input wire logic              fmt_error
);
   logic gated;
   logic fs_on;
   logic ls_on;
   assign gated = (cfg.mode == MODE_GATED);
   assign fs_on = frame_sync_in ^ cfg.inv_frame;
   assign ls_on = line_sync_in ^ cfg.inv_line;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   valid_pulse_a: assert property (
      pix_out.valid |=> !pix_out.valid) else $error("valid too long");
   error_quiet_a: assert property (
      fmt_error |-> !pix_out.valid) else $error("capture while refused");
   gap_ignore_a: assert property (
      gated && pix_out.valid |-> $past(ls_on, 4))
      else $error("pixel taken outside line");
   gated_data_a: assert property (
      gated && cfg.fmt == FMT_GENERIC && pix_out.valid
      |-> pix_out.data == $past(sensor_pixel_bus, 4))
      else $error("gated data differs from bus");
   frame_follow_a: assert property (
      gated && $rose(fs_on) |-> ##[1:5] frame_sync_out)
      else $error("frame start not seen");
   line_end_a: assert property (
      gated && $fell(ls_on) |-> ##[1:6] pix_out.line_end)
      else $error("line end missing");
   active_only_a: assert property (
      !gated && pix_out.valid |-> line_sync_out)
      else $error("pixel outside active line");
   mode_reject_a: assert property (
      cfg.mode == MODE_BT_SINGLE && cfg.fmt == FMT_YUV20
      |-> ##[1:4] fmt_error) else $error("wide format not refused");
endmodule : cvic_capture_monitor

bind cvic_capture cvic_capture_monitor mon_u (.clk(clk), .sys_rst(sys_rst),
   .cfg(cfg), .sensor_pixel_clock(sensor_pixel_clock),
   .frame_sync_in(frame_sync_in), .line_sync_in(line_sync_in),
   .sensor_pixel_bus(sensor_pixel_bus), .pix_out(pix_out),
   .frame_sync_out(frame_sync_out), .line_sync_out(line_sync_out),
   .fmt_error(fmt_error));

// ### tb/cvic_sensor_model.sv
// Sensor model: pixel clock, sync levels and pixel bus
`timescale 1ns/1ps
module cvic_sensor_model
   import cvic_pkg::*;
(
   // Bench clock that times the sensor
   input  wire logic              clk,
   // Sensor pins
   output logic                   sensor_pixel_clock,
   output logic                   frame_sync_in,
   output logic                   line_sync_in,
   output logic [DATA_W-1:0]      sensor_pixel_bus
);
   initial begin
      sensor_pixel_clock = 1'b1;
      frame_sync_in      = 1'b0;
      line_sync_in       = 1'b0;
      sensor_pixel_bus   = '0;
   end
   // One word per 320 ns clock; data is set while the clock is low
   task automatic word(input logic [DATA_W-1:0] d);
      sensor_pixel_bus   <= d;
      sensor_pixel_clock <= 1'b0;
      repeat (4) @(posedge clk);
      sensor_pixel_clock <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : word
   // Clock stands still here, so the bus is no longer held
   task automatic sync(input logic f, input logic l);
      frame_sync_in    <= f;
      line_sync_in     <= l;
      sensor_pixel_bus <= ~sensor_pixel_bus;
      repeat (4) @(posedge clk);
   endtask : sync
   task automatic code(input logic [9:0] st);
      word({PRE_ONES, PRE_ONES});
      word({PRE_ZEROS, PRE_ZEROS});
      word({PRE_ZEROS, PRE_ZEROS});
      word({st, st});
   endtask : code
endmodule : cvic_sensor_model

// ### tb/test_camera_video_input_capture.sv
// Testbench: capture in gated, single and dual embedded modes
`timescale 1ns/1ps
module test_camera_video_input_capture;
   import cvic_pkg::*;
   logic              clk, sys_rst, pclk, fs_in, ls_in;
   logic              fs_out, ls_out, err, fs_seen;
   cvic_cfg_t         cfg;
   logic [DATA_W-1:0] bus;
   cvic_pix_t         pix;
   logic [31:0]       seed = 32'hF;
   logic [19:0]       exp_q[$];
   int                errors = 0;
   int                n_compared = 0;

   cvic_capture dut_u (.clk(clk), .sys_rst(sys_rst), .cfg(cfg),
      .sensor_pixel_clock(pclk), .frame_sync_in(fs_in),
      .line_sync_in(ls_in), .sensor_pixel_bus(bus), .pix_out(pix),
      .frame_sync_out(fs_out), .line_sync_out(ls_out), .fmt_error(err));
   cvic_sensor_model sm_u (.clk(clk), .sensor_pixel_clock(pclk),
      .frame_sync_in(fs_in), .line_sync_in(ls_in), .sensor_pixel_bus(bus));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [19:0] pixw();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      // Top bits fixed so a pixel never looks like a preamble word
      return {2'h1, seed[17:0]};
   endfunction : pixw
   function automatic logic [9:0] ext8(input logic [9:0] c);
      return {c[9:2], c[9:8]};
   endfunction : ext8

   task automatic check(input logic [19:0] got, input logic [19:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   always @(posedge clk) begin
      if (pix.frame_start === 1'b1) fs_seen <= 1'b1;
      if (pix.valid === 1'b1 && exp_q.size() == 0) check(pix.data, ~pix.data);
      else if (pix.valid === 1'b1) check(pix.data, exp_q.pop_front());
   end

   task automatic start(input logic [1:0] m, input logic [2:0] f,
                        input logic i);
      sys_rst <= 1'b1;
      cfg     <= '{mode: m, fmt: f, inv_frame: i, inv_line: i};
      fs_seen <= 1'b0;
      sm_u.sync(i, i);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : start
   task automatic done(input string name);
      repeat (10) @(posedge clk);
      check(20'(exp_q.size()), 20'h0);
      exp_q.delete();
      $display("test %s finished", name);
   endtask : done

   task automatic gated(input logic i);
      logic [19:0] d;
      start(MODE_GATED, FMT_GENERIC, i);
      sm_u.sync(!i, i);
      sm_u.sync(!i, !i);
      for (int k = 0; k < 6; k++) begin
         d = pixw() ^ 20'hC0000;
         exp_q.push_back(d);
         sm_u.word(d);
      end
      sm_u.sync(!i, i);
      sm_u.word(20'h5A5A5);
      check(20'(fs_seen), 20'h1);
      done("gated");
   endtask : gated
   task automatic dual();
      logic [19:0] d;
      start(MODE_BT_DUAL, FMT_YUV20, seed[3]);
      sm_u.word(pixw());
      sm_u.code(10'h200);
      for (int k = 0; k < 4; k++) begin
         d = pixw();
         exp_q.push_back(d);
         sm_u.word(d);
         if (k == 1) sm_u.sync(1'b1, 1'b1);
      end
      check(20'(ls_out), 20'h1);
      check(20'(fs_out), 20'h1);
      sm_u.code(10'h240);
      sm_u.word(pixw());
      check(20'(ls_out), 20'h0);
      done("dual");
   endtask : dual
   task automatic single();
      logic [19:0] a, b;
      start(MODE_BT_SINGLE, FMT_YUV8, seed[4]);
      sm_u.code(10'h200);
      for (int k = 0; k < 2; k++) begin
         a = pixw();
         b = pixw();
         exp_q.push_back({ext8(a[19:10]), ext8(b[19:10])});
         sm_u.word(a);
         sm_u.word(b);
      end
      sm_u.word(pixw());
      sm_u.code(10'h240);
      done("single");
   endtask : single
   task automatic refused(input logic [1:0] m, input logic [2:0] f);
      start(m, f, seed[5]);
      sm_u.code(10'h200);
      sm_u.word(pixw());
      sm_u.word(pixw());
      sm_u.code(10'h240);
      check(20'(err), 20'h1);
      done("refused");
   endtask : refused

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   initial begin
      #200000;
      errors++;
      finish_test();
   end
   initial begin
      sys_rst = 1'b1;
      cfg     = '0;
      fs_seen = 1'b0;
      @(posedge clk);
      gated(1'b0);
      gated(1'b1);
      dual();
      single();
      refused(MODE_BT_SINGLE, FMT_YUV20);
      refused(MODE_BT_DUAL, FMT_YUV8);
      finish_test();
   end
endmodule : test_camera_video_input_capture
